// ==== design/ctsr_regs.vh ====
// register offsets, field positions and reset values of the collision,
// transmit length, bit rate and converter result register group
// assumes: included by the register bank, word index = printed offset
`ifndef CTSR_REGS_VH
`define CTSR_REGS_VH
`define CTSR_IDX_COLL 8'h1c
`define CTSR_IDX_TXU 8'h1d
`define CTSR_IDX_TXL 8'h1e
`define CTSR_IDX_RATE 8'h1f
`define CTSR_IDX_ADC 8'h20
`define CTSR_IDX_IRQ_STAT 8'h30
`define CTSR_IDX_IRQ_MASK 8'h31
`define CTSR_IDX_CTRL 8'h32
`define CTSR_RST_VAL 8'h00
`define CTSR_MAX_TX_BYTES 13'h1fff
`define CTSR_ANTICOLL_MAX_BYTES 4'h9
`define CTSR_IRQ_COLL 0
`define CTSR_IRQ_PAR 1
`define CTSR_IRQ_RATE 2
`define CTSR_IRQ_ADC 3
`endif

// ==== design/ctsr_bank.v ====
// collision / transmit length / bit rate / converter result register bank
// plus local interrupt status, mask and control words above the readouts
// assumes: avalon-mm slave on word addresses, events from the framing
// logic arrive as one-cycle pulses on the same clock
//
// Contract
// R1: collision byte count in bits 7:4
// R2: collision bit count in bits 3:1
// R3: parity collision flag, first collision only
// R4: longer message collision leaves readout unchanged
// R5: readouts clear at reset and restore defaults
// R6: software writes 13-bit count split over 1dh/1eh
// R7: byte count limited to 8191
// R8: bits 2:0 of 1eh are split bits
// R9: split anticollision frame sent without parity; code also requires iso_a (ctrl bit 1) set
// R10: transmit length registers clear on defaults
// R11: detected bit rate code in bits 7:4
// R12: parity irq on wupa with anticollision split; code also requires card_idle high
// R13: last converter result readable at 20h
// R14: low four bits of rate readout read zero
//
// Added by the designer: the Avalon-MM register port.
`timescale 1ns/1ps
`include "ctsr_regs.vh"
module ctsr_bank (
  input wire clock, // 20 mhz clock
  input wire rst, // synchronous reset, active high
  input wire set_default, // restore-defaults command pulse
  input wire [7:0] avs_address, // word address
  input wire avs_read, // read request
  input wire avs_write, // write request
  input wire [31:0] avs_writedata, // write data
  input wire [3:0] avs_byteenable, // byte enables
  output reg [31:0] avs_readdata, // read data
  output wire avs_waitrequest, // wait request
  input wire coll_evt, // collision detected pulse
  input wire [3:0] coll_bytes, // full bytes before collision
  input wire [2:0] coll_bits, // bits before collision in byte
  input wire coll_in_parity, // collision hit a parity bit
  input wire coll_frame_long, // message beyond anticollision range
  input wire rate_evt, // bit rate recognised pulse
  input wire [3:0] rate_code, // recognised bit rate code
  input wire adc_evt, // conversion done pulse
  input wire [7:0] adc_value, // conversion result
  input wire wupa_cmd, // wupa command issued pulse
  input wire card_idle, // card in idle state
  output reg [12:0] tx_byte_count, // full bytes to send
  output reg [2:0] tx_split_bits, // bits of trailing split byte
  output reg tx_no_parity, // send without parity generation
  output wire parity_err_evt, // parity error event
  output wire irq // level interrupt
);
  reg [7:0] coll_q;
  reg [7:0] coll_d;
  reg coll_seen_q;
  reg coll_seen_d;
  reg [7:0] txu_q;
  reg [7:0] txu_d;
  reg [7:0] txl_q;
  reg [7:0] txl_d;
  reg [3:0] rate_q;
  reg [3:0] rate_d;
  reg [7:0] adc_q;
  reg [7:0] adc_d;
  reg [3:0] stat_q;
  reg [3:0] stat_d;
  reg [3:0] mask_q;
  reg [3:0] mask_d;
  reg [1:0] ctrl_q;
  reg [1:0] ctrl_d;
  reg ack_q;
  reg ack_d;
  reg [31:0] rd_d;
  reg [12:0] tx_count_d;
  reg [2:0] tx_split_d;
  reg tx_no_par_d;
  wire anticoll;
  wire iso_a;
  wire req;
  wire wr_en;
  wire rd_start;
  wire clr;
  wire hit_coll;
  wire hit_txu;
  wire hit_txl;
  wire hit_rate;
  wire hit_adc;
  wire hit_stat;
  wire hit_mask;
  wire hit_ctrl;
  wire wr_txu;
  wire wr_txl;
  wire wr_stat;
  wire wr_mask;
  wire wr_ctrl;
  wire coll_take;
  wire split_nonzero;
  wire [3:0] evt;

  // ------------------------------------------------------------
  // bus handshake
  // ------------------------------------------------------------
  // one wait cycle: a request is answered at its second edge, where a
  // write lands and the read data captured at the first edge stand
  assign req = avs_read | avs_write;
  assign avs_waitrequest = req & ~ack_q;
  assign rd_start = avs_read & ~ack_q;
  assign wr_en = avs_write & ack_q & avs_byteenable[0];
  assign clr = rst | set_default;
  assign anticoll = ctrl_q[0];
  assign iso_a = ctrl_q[1];

  always @* begin
    ack_d = req & ~ack_q;
  end

  always @(posedge clock) begin
    if (rst)
      ack_q <= 1'b0;
    else
      ack_q <= ack_d;
  end

  // ------------------------------------------------------------
  // address decode
  // ------------------------------------------------------------
  assign hit_coll = (avs_address == `CTSR_IDX_COLL);
  assign hit_txu = (avs_address == `CTSR_IDX_TXU);
  assign hit_txl = (avs_address == `CTSR_IDX_TXL);
  assign hit_rate = (avs_address == `CTSR_IDX_RATE);
  assign hit_adc = (avs_address == `CTSR_IDX_ADC);
  assign hit_stat = (avs_address == `CTSR_IDX_IRQ_STAT);
  assign hit_mask = (avs_address == `CTSR_IDX_IRQ_MASK);
  assign hit_ctrl = (avs_address == `CTSR_IDX_CTRL);
  // read-only and unmapped words swallow writes
  assign wr_txu = wr_en & hit_txu;
  assign wr_txl = wr_en & hit_txl;
  assign wr_stat = wr_en & hit_stat;
  assign wr_mask = wr_en & hit_mask;
  assign wr_ctrl = wr_en & hit_ctrl;

  // ------------------------------------------------------------
  // collision readout
  // ------------------------------------------------------------
  // a collision in a frame beyond the anticollision range leaves the
  // readout and the first-collision memory alone
  assign coll_take = coll_evt & ~coll_frame_long; // R4

  always @* begin
    coll_d = coll_q;
    coll_seen_d = coll_seen_q;
    if (coll_take) begin
      coll_seen_d = 1'b1;
      coll_d[7:4] = coll_bytes; // R1
      coll_d[3:1] = coll_bits; // R2
      coll_d[0] = coll_in_parity & ~coll_seen_q; // R3
    end
  end

  always @(posedge clock) begin
    if (clr) begin
      coll_q <= `CTSR_RST_VAL; // R5
      coll_seen_q <= 1'b0;
    end else begin
      coll_q <= coll_d;
      coll_seen_q <= coll_seen_d;
    end
  end

  // ------------------------------------------------------------
  // transmit length
  // ------------------------------------------------------------
  always @* begin
    txu_d = txu_q;
    txl_d = txl_q;
    if (wr_txu)
      txu_d = avs_writedata[7:0]; // R6
    if (wr_txl)
      txl_d = avs_writedata[7:0]; // R6
  end

  always @(posedge clock) begin
    if (clr) begin
      txu_q <= `CTSR_RST_VAL; // R10
      txl_q <= `CTSR_RST_VAL; // R10
    end else begin
      txu_q <= txu_d;
      txl_q <= txl_d;
    end
  end

  // the framing logic sees the length one cycle after the registers;
  // thirteen bits cannot express more than 8191 bytes
  assign split_nonzero = (txl_q[2:0] != 3'h0);

  always @* begin
    tx_count_d = {txu_q, txl_q[7:3]} & `CTSR_MAX_TX_BYTES; // R7
    tx_split_d = txl_q[2:0]; // R8
    tx_no_par_d = iso_a & anticoll & split_nonzero; // R9
  end

  always @(posedge clock) begin
    if (rst) begin
      tx_byte_count <= 13'h0;
      tx_split_bits <= 3'h0;
      tx_no_parity <= 1'b0;
    end else begin
      tx_byte_count <= tx_count_d;
      tx_split_bits <= tx_split_d;
      tx_no_parity <= tx_no_par_d;
    end
  end

  // judged on the split count the framing logic is using
  assign parity_err_evt = wupa_cmd & anticoll & card_idle
    & (tx_split_bits != 3'h0); // R12

  // ------------------------------------------------------------
  // rate and converter readouts
  // ------------------------------------------------------------
  always @* begin
    rate_d = rate_q;
    adc_d = adc_q;
    if (rate_evt)
      rate_d = rate_code; // R11
    if (adc_evt)
      adc_d = adc_value; // R13
  end

  always @(posedge clock) begin
    if (clr) begin
      rate_q <= 4'h0; // R5
      adc_q <= `CTSR_RST_VAL; // R5
    end else begin
      rate_q <= rate_d;
      adc_q <= adc_d;
    end
  end

  // ------------------------------------------------------------
  // interrupts and control
  // ------------------------------------------------------------
  assign evt[`CTSR_IRQ_COLL] = coll_take;
  assign evt[`CTSR_IRQ_PAR] = parity_err_evt;
  assign evt[`CTSR_IRQ_RATE] = rate_evt;
  assign evt[`CTSR_IRQ_ADC] = adc_evt;
  assign irq = |(stat_q & mask_q);

  // a new event wins over a write-one clear in the same cycle
  always @* begin
    stat_d = stat_q | evt;
    mask_d = mask_q;
    ctrl_d = ctrl_q;
    if (wr_stat)
      stat_d = (stat_q & ~avs_writedata[3:0]) | evt;
    if (wr_mask)
      mask_d = avs_writedata[3:0];
    if (wr_ctrl)
      ctrl_d = avs_writedata[1:0];
  end

  // status, mask and control survive the restore-defaults command
  always @(posedge clock) begin
    if (rst) begin
      stat_q <= 4'h0;
      mask_q <= 4'h0;
      ctrl_q <= 2'h0;
    end else begin
      stat_q <= stat_d;
      mask_q <= mask_d;
      ctrl_q <= ctrl_d;
    end
  end

  // ------------------------------------------------------------
  // read data
  // ------------------------------------------------------------
  // unmapped words read zero; so does the rate readout's low nibble
  always @* begin
    rd_d = 32'h0;
    if (hit_coll)
      rd_d = {24'h0, coll_q};
    if (hit_txu)
      rd_d = {24'h0, txu_q};
    if (hit_txl)
      rd_d = {24'h0, txl_q};
    if (hit_rate)
      rd_d = {24'h0, rate_q, 4'h0}; // R14
    if (hit_adc)
      rd_d = {24'h0, adc_q}; // R13
    if (hit_stat)
      rd_d = {28'h0, stat_q};
    if (hit_mask)
      rd_d = {28'h0, mask_q};
    if (hit_ctrl)
      rd_d = {30'h0, ctrl_q};
  end

  always @(posedge clock) begin
    if (rst)
      avs_readdata <= 32'h0;
    else if (rd_start)
      avs_readdata <= rd_d;
  end
endmodule

// ==== testbench/ctsr_sva.sv ====
// port checks of ctsr_bank
// assumes: one clock, bound after the module
`timescale 1ns/1ps
module ctsr_sva (
  input wire clock, rst, set_default, avs_read, avs_write, // control
  input wire avs_waitrequest, wupa_cmd, card_idle, // handshake, wupa command and card state
  input wire tx_no_parity, parity_err_evt, // frame flags
  input wire [7:0] avs_address, // address
  input wire [31:0] avs_writedata, avs_readdata, // data
  input wire [3:0] avs_byteenable, // lanes
  input wire [12:0] tx_byte_count, // byte count
  input wire [2:0] tx_split_bits // split bits
);
  wire rda = avs_read & ~avs_waitrequest;
  wire wra = avs_write & ~avs_waitrequest & avs_byteenable[0];
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  a_one_wait: assert property ((avs_read | avs_write) && avs_waitrequest
    |=> !avs_waitrequest) else $error("answer late");
  a_count_load: assert property (
    wra && avs_address == 8'h1d |->
    ##2 tx_byte_count[12:5] == $past(avs_writedata[7:0], 2))
    else $error("count load");
  a_split_load: assert property (
    wra && avs_address == 8'h1e |->
    ##2 tx_split_bits == $past(avs_writedata[2:0], 2))
    else $error("split load");
  a_dflt_clear: assert property (set_default |=> ##1
    tx_byte_count == 13'h0000 && tx_split_bits == 3'h0)
    else $error("defaults");
  a_par_cause: assert property (parity_err_evt |->
    wupa_cmd && card_idle && tx_split_bits != 3'h0) else $error("par");
  a_par_fire: assert property (tx_no_parity && wupa_cmd && card_idle
    |-> parity_err_evt) else $error("par missing");
  a_no_parity: assert property (
    tx_no_parity |-> tx_split_bits != 3'h0) else $error("no parity");
  a_rate_low: assert property (rda && avs_address == 8'h1f
    |-> avs_readdata[3:0] == 4'h0) else $error("rate low bits");
  c_write: cover property (wra);
  c_par: cover property (parity_err_evt);
  c_dflt: cover property (set_default);
endmodule
bind ctsr_bank ctsr_sva sva_u (.*);

// ==== testbench/ctsr_host.sv ====
// avalon-mm master standing in for host software
// assumes: slave on the same clock, answers with waitrequest
`timescale 1ns/1ps
module ctsr_host (
  input wire clock, // clock
  input wire avs_waitrequest, // wait request
  input wire [31:0] avs_readdata, // read data
  output reg [7:0] avs_address = 8'h00, // address
  output reg avs_read = 1'b0, // read
  output reg avs_write = 1'b0, // write
  output reg [31:0] avs_writedata = 32'h00000000 // write data
);
  task automatic xfer(input w, input [7:0] a, d, output [7:0] q);
    @(posedge clock);
    avs_address <= a;
    avs_writedata <= {24'h000000, d};
    avs_read <= !w;
    avs_write <= w;
    @(posedge clock);
    while (avs_waitrequest) @(posedge clock);
    q = avs_readdata[7:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
endmodule

// ==== testbench/ctsr_bank_tb_top.sv ====
// self-checking bench of ctsr_bank
// assumes: host model drives the register bus
`timescale 1ns/1ps
module ctsr_bank_tb_top;
  reg clock = 1'b0, rst = 1'b1, set_default = 1'b0, coll_evt = 1'b0;
  reg coll_in_parity = 1'b0, coll_frame_long = 1'b0, rate_evt = 1'b0;
  reg adc_evt = 1'b0, wupa_cmd = 1'b0, card_idle = 1'b0;
  reg [3:0] coll_bytes = 4'h0, rate_code = 4'h0;
  reg [2:0] coll_bits = 3'h0;
  reg [3:0] avs_byteenable = 4'h1;
  reg [7:0] adc_value = 8'h00, q;
  wire [7:0] avs_address;
  wire avs_read, avs_write, avs_waitrequest, tx_no_parity;
  wire parity_err_evt, irq;
  wire [31:0] avs_writedata, avs_readdata;
  wire [12:0] tx_byte_count;
  wire [2:0] tx_split_bits;
  integer fails = 0, check_count = 0, cyc = 0, i;
  ctsr_bank dut_u (.*);
  ctsr_host host_u (.*);
  initial forever #25 clock = ~clock;
  task wrap_up;
    if (fails == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      fails = fails + 1;
      wrap_up;
    end
  end
  task ck(input string n, input [12:0] s, e);
    check_count = check_count + 1;
    if (s !== e) begin
      fails = fails + 1;
      $display("ERROR %s exp %h seen %h", n, e, s);
    end
  endtask
  task wr(input [7:0] a, d);
    host_u.xfer(1'b1, a, d, q);
  endtask
  task rc(input [7:0] a, e);
    host_u.xfer(1'b0, a, 8'h00, q);
    ck("readdata", {5'h00, q}, {5'h00, e});
  endtask
  task coll(input [3:0] b, input [2:0] t, input p, l);
    @(posedge clock);
    {coll_evt, coll_bytes, coll_bits, coll_in_parity} <= {1'b1, b, t, p};
    coll_frame_long <= l;
    @(posedge clock);
    coll_evt <= 1'b0;
  endtask
  initial begin
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    for (i = 28; i <= 32; i = i + 1) rc(i[7:0], 8'h00);
    wr(8'h1d, 8'hff);
    wr(8'h1e, 8'hfb);
    wr(8'h32, 8'h03);
    rc(8'h1e, 8'hfb);
    ck("tx_byte_count", tx_byte_count, 13'h1fff);
    ck("tx_split_bits", {10'h000, tx_split_bits}, 13'h0003);
    ck("tx_no_parity", {12'h000, tx_no_parity}, 13'h0001);
    @(posedge clock);
    {wupa_cmd, card_idle} <= 2'b11;
    #1 ck("parity_err_evt", {12'h000, parity_err_evt}, 13'h0001);
    @(posedge clock);
    wupa_cmd <= 1'b0;
    wr(8'h1e, 8'hf8);
    coll(4'h5, 3'h3, 1'b1, 1'b0);
    ck("tx_no_parity", {12'h000, tx_no_parity}, 13'h0000);
    rc(8'h1c, 8'h57);
    coll(4'h2, 3'h2, 1'b1, 1'b0);
    rc(8'h1c, 8'h24);
    coll(4'h9, 3'h7, 1'b0, 1'b1);
    rc(8'h1c, 8'h24);
    @(posedge clock);
    {rate_evt, rate_code, adc_evt, adc_value} <= {6'h35, 8'h5a};
    @(posedge clock);
    {rate_evt, adc_evt} <= 2'b00;
    rc(8'h1f, 8'ha0);
    rc(8'h20, 8'h5a);
    rc(8'h30, 8'h0f);
    ck("irq", {12'h000, irq}, 13'h0000);
    wr(8'h31, 8'h01);
    #1 ck("irq", {12'h000, irq}, 13'h0001);
    rc(8'h31, 8'h01);
    wr(8'h30, 8'h0f);
    #1 ck("irq", {12'h000, irq}, 13'h0000);
    rc(8'h30, 8'h00);
    rc(8'h21, 8'h00);
    avs_byteenable <= 4'h0;
    wr(8'h1d, 8'h55);
    avs_byteenable <= 4'h1;
    rc(8'h1d, 8'hff);
    @(posedge clock);
    set_default <= 1'b1;
    @(posedge clock);
    set_default <= 1'b0;
    for (i = 28; i <= 32; i = i + 1) rc(i[7:0], 8'h00);
    coll(4'h1, 3'h1, 1'b1, 1'b0);
    rc(8'h1c, 8'h13);
    wrap_up;
  end
endmodule
